//--- core/dma_pkg.sv
/*
  Shared constants of the four-channel dma controller: register map, control
  field positions, reset values, request-source codes and engine states.
  Assumes a 32-bit APB register bus and a 32-bit system memory port.
*/
package dma_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int          NUM_CH       = 4;
  localparam int          RELOAD_CH    = 2;
  localparam logic [1:0]  RELOAD_LAST  = 2'h3;   // fourth unit of a group

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFF_SAR      = 12'h000;
  localparam logic [11:0] OFF_DAR      = 12'h004;
  localparam logic [11:0] OFF_TCR      = 12'h008;
  localparam logic [11:0] OFF_CHANNEL_CONTROL_REG     = 12'h00c;
  localparam logic [11:0] CH_STRIDE    = 12'h010;
  localparam logic [11:0] OFF_OPR      = 12'h040;

  // ****************************************************************
  // channel_control_reg fields
  // ****************************************************************
  localparam int          CC_DE        = 0;
  localparam int          CC_TE        = 1;
  localparam int          CC_IE        = 2;
  localparam int          CC_TS_LO     = 3;
  localparam int          CC_TS_HI     = 4;
  localparam int          CC_SM_LO     = 5;
  localparam int          CC_SM_HI     = 6;
  localparam int          CC_DM_LO     = 7;
  localparam int          CC_DM_HI     = 8;
  localparam int          CC_BURST     = 9;
  localparam int          CC_RELOAD    = 10;
  localparam int          CC_INDIRECT  = 11;
  localparam int          CC_RS_LSB    = 12;
  localparam int          CC_RS_MSB    = 16;

  localparam logic [4:0]  RS_NONE      = 5'h00;
  localparam logic [4:0]  RS_AUTO      = 5'h01;
  localparam logic [4:0]  RS_PERIPH    = 5'h02;

  // ****************************************************************
  // controller_operation_reg fields
  // ****************************************************************
  localparam int          OR_DME       = 0;
  localparam int          OR_NMI_SEEN_FLAG      = 1;
  localparam int          OR_AE        = 2;

  // ****************************************************************
  // reset values and access widths
  // ****************************************************************
  localparam logic [31:0] ADDR_RST     = 32'h0000_0000;
  localparam logic [31:0] TCR_RST      = 32'h0000_0000;
  localparam logic [31:0] CHANNEL_CONTROL_REG_RST     = 32'h0000_0000;
  localparam logic [15:0] OPR_RST      = 16'h0000;
  localparam logic [3:0]  STRB_WORD    = 4'h3;
  localparam logic [3:0]  STRB_LONG    = 4'hf;

  // ****************************************************************
  // access sizes, step modes, engine states
  // ****************************************************************
  localparam logic [1:0]  SZ_BYTE      = 2'h0;
  localparam logic [1:0]  SZ_WORD      = 2'h1;
  localparam logic [1:0]  SZ_LONG      = 2'h2;
  localparam logic [1:0]  STEP_FIXED   = 2'h0;
  localparam logic [1:0]  STEP_INC     = 2'h1;
  localparam logic [1:0]  STEP_DEC     = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ARB  = 5'b00010,
    ST_PTR  = 5'b00100,
    ST_RD   = 5'b01000,
    ST_WR   = 5'b10000
  } eng_state_t;

endpackage

//--- core/dma_reload_track.sv
/*
  Source-address reload tracker for the reload-capable channel: keeps the
  originally programmed source address and counts completed units in groups.
  Assumes unit_done pulses once per unit and only while reload is enabled.
*/
`timescale 1ns/1ps
module dma_reload_track (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        clr,
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  input  wire logic        unit_done,
  // result
  output logic             wrap,
  output logic [31:0]      orig
);
  import dma_pkg::*;

  logic [1:0]  cnt_q;
  logic [31:0] orig_q;

  // ****************************************************************
  // group counter
  // ****************************************************************
  assign wrap = unit_done && (cnt_q == RELOAD_LAST);
  assign orig = orig_q;

  // counter alone is cleared; addresses and counts keep their values
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
    end else if (clr) begin
      cnt_q <= 2'h0;
    end else if (unit_done) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      orig_q <= ADDR_RST;
    end else if (load) begin
      orig_q <= load_val;
    end
  end

endmodule

//--- core/dma_ctrl.sv
/*
  Four-channel dma controller: APB register file, fixed-priority channel
  selection, dual-address and indirect transfers, channel-2 source reload.
  Assumes a system memory port that holds mem_req until mem_ack, a CPU bus
  arbiter answering cpu_bus_req with cpu_bus_grant, synchronous inputs.
*/
// Design decisions made here: the APB register port and the register addresses.
// Behaviour
// - reload source address every four transfers
// - after fourth reload unit halt, release, clear flag
// - reload off burst keeps bus and steps on
// - destination steps per its own mode always
// - end interrupt only at zero count with enable
// - in burst, peripheral flag clear at group end with reload, at zero count without
// - indirect: pointer read, data read, write
// - pointer read is longword, source steps by a longword
// - operation reg 16-bit only, others 16/32
// - nmi sets flag even when idle
// - reload counter cleared by stop events
// - zero count sets end flag, interrupt if enabled
`timescale 1ns/1ps
module dma_ctrl (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // apb register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // system memory master
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [1:0]       mem_size,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // cpu bus arbitration
  output logic             cpu_bus_req,
  input  wire logic        cpu_bus_grant,
  // peripheral requests
  input  wire logic [3:0]  xfer_req,
  output logic [3:0]       req_flag_clr,
  // system events
  input  wire logic        nmi,
  input  wire logic        standby,
  // end-of-transfer interrupts
  output logic [3:0]       end_irq
);
  import dma_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] step_addr(input logic [31:0] a,
                                            input logic [1:0]  mode,
                                            input logic [1:0]  sz);
    logic [31:0] n;
    n = 32'h1 << sz;
    case (mode)
      STEP_INC: step_addr = a + n;
      STEP_DEC: step_addr = a - n;
      default:  step_addr = a;
    endcase
  endfunction

  function automatic logic misaligned(input logic [31:0] a, input logic [1:0] sz);
    case (sz)
      SZ_LONG: misaligned = (a[1:0] != 2'h0);
      SZ_WORD: misaligned = a[0];
      default: misaligned = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0] sar_q  [NUM_CH];
  logic [31:0] dar_q  [NUM_CH];
  logic [31:0] tcr_q  [NUM_CH];
  logic [31:0] channel_control_reg_q [NUM_CH];
  logic [15:0] opr_q;
  eng_state_t  st_q;
  logic [1:0]  ch_q;
  logic [31:0] data_q;
  logic [31:0] prdata_q;
  logic        mem_req_q;
  logic        mem_we_q;
  logic [31:0] mem_addr_q;
  logic [1:0]  mem_size_q;
  logic [31:0] mem_wdata_q;
  logic        bus_req_q;
  logic [3:0]  flag_clr_q;

  // ****************************************************************
  // register decode
  // ****************************************************************
  logic        is_ch;
  logic        is_opr;
  logic [1:0]  rch;
  logic [11:0] roff;
  logic        bad_strb;
  logic        dec_err;
  logic        apb_wr;

  assign is_ch    = (paddr < OFF_OPR) && (paddr[1:0] == 2'h0);
  assign is_opr   = (paddr == OFF_OPR);
  assign rch      = paddr[5:4];
  assign roff     = paddr & (CH_STRIDE - 12'h001);
  // operation reg takes low halfword only; others halfword or longword
  assign bad_strb = pwrite && (is_opr ? (pstrb != STRB_WORD)
                               : (pstrb != STRB_WORD && pstrb != STRB_LONG));
  assign dec_err  = !(is_ch || is_opr) || bad_strb;
  assign apb_wr   = psel && penable && pwrite && !dec_err;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && dec_err;
  assign prdata   = prdata_q;

  // read data latched in setup so it comes from a flop in access
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (is_opr) begin
        prdata_q <= {16'h0, opr_q};
      end else if (is_ch) begin
        case (roff)
          OFF_SAR: prdata_q <= sar_q[rch];
          OFF_DAR: prdata_q <= dar_q[rch];
          OFF_TCR: prdata_q <= tcr_q[rch];
          default: prdata_q <= channel_control_reg_q[rch];
        endcase
      end else begin
        prdata_q <= 32'h0;
      end
    end
  end

  // ****************************************************************
  // current channel fields and next values
  // ****************************************************************
  logic [31:0] cc;
  logic [1:0]  ts;
  logic        indirect;
  logic        burst;
  logic        periph;
  logic [31:0] sar_nx;
  logic [31:0] dar_nx;
  logic [31:0] tcr_nx;
  logic        halt_all;
  logic        unit_done;
  logic        wrap;
  logic [31:0] orig;
  logic        reload_on;
  logic        stop_now;
  logic        end_now;

  assign cc        = channel_control_reg_q[ch_q];
  assign ts        = {cc[CC_TS_HI], cc[CC_TS_LO]};
  assign indirect  = cc[CC_INDIRECT];
  assign burst     = cc[CC_BURST];
  assign periph    = (cc[CC_RS_MSB:CC_RS_LSB] == RS_PERIPH);
  assign reload_on = (ch_q == 2'(RELOAD_CH)) && cc[CC_RELOAD];
  // pointer reads move the source by a longword
  assign sar_nx    = step_addr(sar_q[ch_q], {cc[CC_SM_HI], cc[CC_SM_LO]},
                               indirect ? SZ_LONG : ts);
  assign dar_nx    = step_addr(dar_q[ch_q], {cc[CC_DM_HI], cc[CC_DM_LO]}, ts);
  assign tcr_nx    = tcr_q[ch_q] - 32'h1;
  assign halt_all  = !opr_q[OR_DME] || opr_q[OR_NMI_SEEN_FLAG] || opr_q[OR_AE];
  assign unit_done = (st_q == ST_WR) && mem_ack;
  assign end_now   = unit_done && (tcr_nx == 32'h0);
  assign stop_now  = end_now || halt_all || !cc[CC_DE] || wrap || !burst;

  // ****************************************************************
  // channel selection
  // ****************************************************************
  logic [3:0] ready;
  logic [1:0] pick;
  logic       any_ready;

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ready[i] = !halt_all && channel_control_reg_q[i][CC_DE] && !channel_control_reg_q[i][CC_TE]
                 && (tcr_q[i] != 32'h0) && !flag_clr_q[i]
                 && ((channel_control_reg_q[i][CC_RS_MSB:CC_RS_LSB] == RS_AUTO)
                     || ((channel_control_reg_q[i][CC_RS_MSB:CC_RS_LSB] == RS_PERIPH) && xfer_req[i]));
    end
    pick = 2'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (ready[i]) begin
        pick = 2'(i);
      end
    end
  end
  assign any_ready = |ready;

  // ****************************************************************
  // reload tracking
  // ****************************************************************
  logic trk_clr;
  logic sar2_wr;

  assign trk_clr = halt_all || !channel_control_reg_q[RELOAD_CH][CC_DE]
                   || channel_control_reg_q[RELOAD_CH][CC_TE] || standby;
  assign sar2_wr = apb_wr && is_ch && (rch == 2'(RELOAD_CH)) && (roff == OFF_SAR);

  dma_reload_track u_track (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clr       (trk_clr),
    .load      (sar2_wr),
    .load_val  (merge(sar_q[RELOAD_CH], pwdata, pstrb)),
    .unit_done (unit_done && reload_on),
    .wrap      (wrap),
    .orig      (orig)
  );

  // ****************************************************************
  // channel registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        sar_q[i]  <= ADDR_RST;
        dar_q[i]  <= ADDR_RST;
        tcr_q[i]  <= TCR_RST;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (unit_done && ch_q == 2'(i)) begin
          sar_q[i] <= wrap ? orig : sar_nx;
          dar_q[i] <= dar_nx;
          tcr_q[i] <= tcr_nx;
        end else if (apb_wr && is_ch && rch == 2'(i)) begin
          if (roff == OFF_SAR) sar_q[i] <= merge(sar_q[i], pwdata, pstrb);
          if (roff == OFF_DAR) dar_q[i] <= merge(dar_q[i], pwdata, pstrb);
          if (roff == OFF_TCR) tcr_q[i] <= merge(tcr_q[i], pwdata, pstrb);
        end
      end
    end
  end

  // end flag: hardware set wins over a software write of zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        channel_control_reg_q[i] <= CHANNEL_CONTROL_REG_RST;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (apb_wr && is_ch && rch == 2'(i) && roff == OFF_CHANNEL_CONTROL_REG) begin
          channel_control_reg_q[i] <= merge(channel_control_reg_q[i], pwdata, pstrb)
                       & ~(32'h1 << CC_TE | ~pwdata & 32'h0)
                       | (channel_control_reg_q[i] & pwdata & (32'h1 << CC_TE));
        end
        if (end_now && ch_q == 2'(i)) begin
          channel_control_reg_q[i][CC_TE] <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // operation register
  // ****************************************************************
  logic ae_set;

  assign ae_set = (st_q == ST_ARB) && cpu_bus_grant && !indirect
                  && misaligned(sar_q[ch_q], ts);

  // flags clear by writing zero; a same-cycle event keeps them set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opr_q <= OPR_RST;
    end else begin
      if (apb_wr && is_opr) begin
        opr_q[OR_DME]  <= pwdata[OR_DME];
        opr_q[OR_NMI_SEEN_FLAG] <= opr_q[OR_NMI_SEEN_FLAG] & pwdata[OR_NMI_SEEN_FLAG];
        opr_q[OR_AE]   <= opr_q[OR_AE] & pwdata[OR_AE];
      end
      if (nmi) begin
        opr_q[OR_NMI_SEEN_FLAG] <= 1'b1;
      end
      if (ae_set) begin
        opr_q[OR_AE] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // transfer engine
  // ****************************************************************
  logic [31:0] rd_addr;
  logic [1:0]  rd_size;
  eng_state_t  rd_st;

  // indirect units start with a longword pointer fetch
  assign rd_addr = sar_q[ch_q];
  assign rd_size = indirect ? SZ_LONG : ts;
  assign rd_st   = indirect ? ST_PTR : ST_RD;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= ST_IDLE;
      ch_q        <= 2'h0;
      data_q      <= 32'h0;
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_addr_q  <= 32'h0;
      mem_size_q  <= SZ_BYTE;
      mem_wdata_q <= 32'h0;
      bus_req_q   <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (any_ready) begin
            ch_q      <= pick;
            bus_req_q <= 1'b1;
            st_q      <= ST_ARB;
          end
        end
        ST_ARB: begin
          if (halt_all || !cc[CC_DE]) begin
            bus_req_q <= 1'b0;
            st_q      <= ST_IDLE;
          end else if (cpu_bus_grant) begin
            mem_req_q  <= 1'b1;
            mem_we_q   <= 1'b0;
            mem_addr_q <= rd_addr;
            mem_size_q <= rd_size;
            st_q       <= rd_st;
          end
        end
        ST_PTR: begin
          if (mem_ack) begin
            mem_addr_q <= mem_rdata;
            mem_size_q <= ts;
            st_q       <= ST_RD;
          end
        end
        ST_RD: begin
          if (mem_ack) begin
            data_q      <= mem_rdata;
            mem_we_q    <= 1'b1;
            mem_addr_q  <= dar_q[ch_q];
            mem_wdata_q <= mem_rdata;
            mem_size_q  <= ts;
            st_q        <= ST_WR;
          end
        end
        ST_WR: begin
          if (mem_ack) begin
            mem_we_q <= 1'b0;
            // a unit always finishes its write before any halt
            if (stop_now) begin
              mem_req_q <= 1'b0;
              bus_req_q <= 1'b0;
              st_q      <= ST_IDLE;
            end else begin
              mem_addr_q <= wrap ? orig : sar_nx;
              mem_size_q <= rd_size;
              st_q       <= rd_st;
            end
          end
        end
        default: begin
          mem_req_q <= 1'b0;
          bus_req_q <= 1'b0;
          st_q      <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // request flag clear and outputs
  // ****************************************************************
  // cleared after each unit without burst; in burst at end of count or of a reload group, never mid-burst
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_clr_q <= 4'h0;
    end else begin
      flag_clr_q <= 4'h0;
      if (unit_done && periph && (end_now || wrap || !burst)) begin
        flag_clr_q[ch_q] <= 1'b1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      end_irq[i] = channel_control_reg_q[i][CC_TE] && channel_control_reg_q[i][CC_IE];
    end
  end

  assign mem_req      = mem_req_q;
  assign mem_we       = mem_we_q;
  assign mem_addr     = mem_addr_q;
  assign mem_size     = mem_size_q;
  assign mem_wdata    = mem_wdata_q;
  assign cpu_bus_req  = bus_req_q;
  assign req_flag_clr = flag_clr_q;

endmodule

//--- sim/dma_ctrl_monitor.sv
/*
  Checker for dma_ctrl: register bus refusals and memory port order.
  Assumes a bind to dma_ctrl; sees only its ports.
*/
`timescale 1ns/1ps
module dma_ctrl_monitor
  import dma_pkg::*;
(
  // clock and reset
  input logic        sys_clk,
  input logic        rst_n,
  // apb
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [3:0]  pstrb,
  input logic        pslverr,
  // memory port
  input logic        mem_req,
  input logic        mem_we,
  input logic [31:0] mem_addr,
  input logic [1:0]  mem_size,
  input logic [31:0] mem_wdata,
  input logic        mem_ack,
  input logic [31:0] mem_rdata,
  // bus and flags
  input logic        cpu_bus_req,
  input logic        cpu_bus_grant,
  input logic [3:0]  req_flag_clr
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire apw = psel && penable && pwrite;
  sequence s_rd_done;
    mem_req && mem_ack && !mem_we;
  endsequence
  a_opr_refuse: assert property (
    apw && paddr == OFF_OPR && pstrb != STRB_WORD |-> pslverr)
    else $error("wide write to operation reg accepted");
  a_opr_word: assert property (
    apw && paddr == OFF_OPR && pstrb == STRB_WORD |-> !pslverr)
    else $error("word write to operation reg refused");
  a_long_ok: assert property (
    apw && paddr < OFF_OPR && paddr[1:0] == 2'h0 && pstrb == STRB_LONG |-> !pslverr)
    else $error("long write to channel reg refused");
  a_mem_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
      && $stable(mem_size) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  a_wr_data: assert property (
    s_rd_done ##1 (mem_req && mem_we) |-> mem_wdata == $past(mem_rdata))
    else $error("write data differs from read data");
  a_ptr_follow: assert property (
    s_rd_done ##1 (mem_req && !mem_we) |-> mem_addr == $past(mem_rdata)
      && $past(mem_size) == SZ_LONG)
    else $error("pointer read not long or not followed");
  a_grant_first: assert property (
    $rose(mem_req) |-> $past(cpu_bus_grant))
    else $error("memory access without bus grant");
  a_req_in_bus: assert property (
    mem_req |-> cpu_bus_req)
    else $error("memory access after bus request dropped");
  a_clr_pulse: assert property (
    req_flag_clr[2] |=> !req_flag_clr[2])
    else $error("flag clear longer than one cycle");
endmodule

bind dma_ctrl dma_ctrl_monitor mon_u (.sys_clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pstrb, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata,
  .mem_ack, .mem_rdata, .cpu_bus_req, .cpu_bus_grant, .req_flag_clr);

//--- sim/mem_partner.sv
/*
  System memory and cpu bus arbiter seen by the controller.
  Assumes requests are held until ack; slow adds two wait cycles.
*/
`timescale 1ns/1ps
module mem_partner (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // pacing
  input  wire logic        slow,
  // memory port
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  // arbitration
  input  wire logic        cpu_bus_req,
  output logic             cpu_bus_grant
);
  // ****************************************************************
  // memory and arbiter
  // ****************************************************************
  logic [1:0] wait_q;
  // content is the address plus an offset; gives distinct pointers
  wire [31:0] word = mem_addr + 32'h0000_1011;
  // data off ack is inverted so stale values never pass
  assign mem_rdata = mem_ack ? word : ~word;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_bus_grant <= 1'b0;
    end else begin
      cpu_bus_grant <= cpu_bus_req;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      wait_q  <= 2'h0;
    end else if (mem_req && !mem_ack && wait_q == (slow ? 2'h2 : 2'h0)) begin
      mem_ack <= 1'b1;
      wait_q  <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      wait_q  <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

//--- sim/tb.sv
/*
  Testbench for dma_ctrl: register bus, reload, burst and indirect.
  Assumes mem_partner as memory; request flag modelled here.
*/
`timescale 1ns/1ps
`define CK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
  import dma_pkg::*;
  // ****************************************************************
  // signals and design
  // ****************************************************************
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic        mem_req, mem_we, mem_ack, cpu_bus_req, cpu_bus_grant, nmi, standby, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd, wa, wd;
  logic [3:0]  pstrb, xfer_req, req_flag_clr, end_irq;
  logic [1:0]  mem_size;
  int          errors, n_checks, nclr, nwr, i;
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;
  dma_ctrl dut_u (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_size,
    .mem_wdata, .mem_ack, .mem_rdata, .cpu_bus_req, .cpu_bus_grant, .xfer_req,
    .req_flag_clr, .nmi, .standby, .end_irq);
  mem_partner mem_u (.sys_clk, .rst_n, .slow, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata, .cpu_bus_req, .cpu_bus_grant);
  // peripheral flag drops on the clear pulse
  always @(posedge sys_clk) begin
    if (req_flag_clr[2]) begin
      xfer_req[2] <= 1'b0;
      nclr++;
    end
    if (mem_req && mem_ack && mem_we) begin
      wa = mem_addr;
      wd = mem_wdata;
      nwr++;
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk) penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0, 4'h0);
    `CK(nm, e, rd)
  endtask
  task automatic cfg(input logic [11:0] b, input logic [31:0] s, d, n, c);
    apb(1'b1, b, s, STRB_LONG);
    apb(1'b1, b + 12'h4, d, STRB_LONG);
    apb(1'b1, b + 12'h8, n, STRB_LONG);
    apb(1'b1, b + 12'hc, c, STRB_LONG);
  endtask
  task automatic waitclr;
    for (i = 0; i < 300 && req_flag_clr[2] !== 1'b1; i++) @(posedge sys_clk);
    `CK("clr seen", 1'b1, req_flag_clr[2])
    repeat (2) @(posedge sys_clk);
  endtask
  task close_out;
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    close_out();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {xfer_req, nmi, standby, slow, errors, n_checks, nclr, nwr} = '0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b1, OFF_OPR, 32'h1, STRB_LONG);
    `CK("opr long", 1'b1, er)
    apb(1'b1, OFF_OPR, 32'h1, STRB_WORD);
    `CK("opr word", 1'b0, er)
    apb(1'b0, 12'h050, 32'h0, 4'h0);
    `CK("hole", 1'b1, er)
    nmi <= 1'b1;
    @(posedge sys_clk) nmi <= 1'b0;
    @(posedge sys_clk);
    rc(OFF_OPR, 32'h3, "nmi flag");
    apb(1'b1, OFF_OPR, 32'h1, STRB_WORD);
    // reload group: burst, count a multiple of four
    cfg(12'h020, 32'h100, 32'h200, 32'h8, 32'h26a5);
    xfer_req[2] <= 1'b1;
    waitclr();
    rc(12'h020, 32'h100, "sar2 group");
    rc(12'h024, 32'h204, "dar2 group");
    rc(12'h028, 32'h4, "tcr2 group");
    `CK("group clr", 1, nclr)
    `CK("bus released", 1'b0, cpu_bus_req)
    `CK("no irq", 1'b0, end_irq[2])
    xfer_req[2] <= 1'b1;
    waitclr();
    rc(12'h028, 32'h0, "tcr2 end");
    rc(12'h020, 32'h100, "sar2 end");
    `CK("end irq", 1'b1, end_irq[2])
    apb(1'b1, 12'h028, 32'h0, STRB_LONG);
    apb(1'b1, 12'h02c, 32'h0, STRB_LONG);
    // reload off, slow memory, no interrupt enable
    slow <= 1'b1;
    nclr = 0;
    cfg(12'h020, 32'h100, 32'h200, 32'h8, 32'h22a1);
    xfer_req[2] <= 1'b1;
    waitclr();
    rc(12'h020, 32'h108, "sar2 burst");
    rc(12'h024, 32'h208, "dar2 burst");
    `CK("burst clr", 1, nclr)
    `CK("irq off", 1'b0, end_irq[2])
    apb(1'b1, 12'h028, 32'h0, STRB_LONG);
    apb(1'b1, 12'h02c, 32'h0, STRB_LONG);
    // indirect byte unit on channel 0
    slow <= 1'b0;
    nwr = 0;
    cfg(12'h000, 32'h340, 32'h500, 32'h1, 32'h1821);
    for (i = 0; i < 300 && nwr == 0; i++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    `CK("ind writes", 1, nwr)
    `CK("ind addr", 32'h500, wa)
    `CK("ind data", 8'h62, wd[7:0])
    rc(12'h000, 32'h344, "sar0 ind");
    rc(12'h008, 32'h0, "tcr0 ind");
    close_out();
  end
endmodule
